// ==== verilog/snvm_target.sv ====
// two-wire serial target in front of a 64K x 8 byte array
// assumes an external pull-up on the data line and a master-driven clock
`timescale 1ns/1ps
`default_nettype none
`include "snvm_regs.svh"

// Summary of operation
// (RULE_01) the array holds 65,536 bytes, each reached by its own 16-bit address.
// (RULE_02) two address bytes after the target address form the full location address, high byte first.
// (RULE_03) the device answers only when its three select inputs match the select bits of the target address.
// (RULE_04) unconnected select inputs read as zero through internal pull-downs.
// (RULE_05) serial bits are sampled on clock rise and changed on clock fall.
// (RULE_06) a high write-protect input blocks all array writes; low or open allows them.
// (RULE_07) each received data byte is written at once with no busy period.
// (RULE_08) each byte moves one bit per clock over the data line.
// (RULE_09) a read-only identification value names maker, density and revision.
// (RULE_10) the data line is only pulled low or released, never driven high.
// (RULE_11) the target address carries type code 1010 in bits 7-4, select bits 3-1 and read flag in bit 0.
// (RULE_12) the address increments after each byte and wraps from FFFF to 0000 without limit.
// (RULE_13) the receiver acknowledges after the eighth bit; reads continue on acknowledge and end on none.
// (RULE_14) a start or stop aborts any operation and readies the device for a new one.
// (RULE_15) clock and data are synchronised and edges, start and stop found from the samples.
module snvm_target
	import snvm_pkg::*;
#(
	parameter int ADDR_W = `SNVM_ADDR_W,
	parameter int DATA_W = `SNVM_DATA_W
) (
	input  wire logic        core_clk_in,              // system clock, 40 MHz
	input  wire logic        sys_rst_in,               // sync reset, active high
	input  wire logic        scl_in,                   // serial clock pin
	input  wire logic        sda_in,                   // serial data pin level
	output logic             sda_out,                  // data pin drive value, always low
	output logic             sda_oe_out,               // high while pulling data low
	input  wire logic [2:0]  device_select_inputs_in,  // strapped select, low when open
	input  wire logic        write_protect_in,         // high locks the array
	output logic [23:0]      ident_out                 // read-only identification
);

	// =====================================================
	// identification, fixed
	assign ident_out = {`SNVM_ID_MAKER, `SNVM_ID_DENSITY, `SNVM_ID_REV};  // see (RULE_09)

	// =====================================================
	// pin conditioning
	snvm_line_t line;
	logic [2:0] sel_s1;
	logic [2:0] sel_s2;
	logic [2:0] sel_s3;
	logic [2:0] sel_q;
	logic [1:0] wp_s;
	logic       wp_s3;
	logic       wp_q;
	logic [2:0] next_sel_s1;
	logic [2:0] next_sel_s2;
	logic [2:0] next_sel_s3;
	logic [2:0] next_sel_q;
	logic [1:0] next_wp_s;
	logic       next_wp_s3;
	logic       next_wp_q;

	snvm_line_sync u_sync (
		.core_clk_in (core_clk_in),
		.sys_rst_in  (sys_rst_in),
		.scl_in      (scl_in),
		.sda_in      (sda_in),
		.line_out    (line)
	);

	// =====================================================
	// strap and protect synchronisers
	// straps and protect: pull-downs make an open pin read zero
	// straps still pass three stages, so a strap moved live cannot glitch a match
	always_comb begin
		next_sel_s1 = device_select_inputs_in;
		next_sel_s2 = sel_s1;
		next_sel_s3 = sel_s2;
		// a change counts once stages two and three agree
		next_sel_q  = (sel_s2 == sel_s3) ? sel_s3 : sel_q;  // see (RULE_03)
		next_wp_s   = {wp_s[0], write_protect_in};
		next_wp_s3  = wp_s[1];
		next_wp_q   = (wp_s[1] == wp_s3) ? wp_s3 : wp_q;  // see (RULE_06)
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			sel_s1 <= 3'h0;  // see (RULE_04)
			sel_s2 <= 3'h0;
			sel_s3 <= 3'h0;
			sel_q  <= 3'h0;
			wp_s   <= 2'h0;
			wp_s3  <= 1'b0;
			wp_q   <= 1'b0;  // see (RULE_06)
		end else begin
			sel_s1 <= next_sel_s1;
			sel_s2 <= next_sel_s2;
			sel_s3 <= next_sel_s3;
			sel_q  <= next_sel_q;
			wp_s   <= next_wp_s;
			wp_s3  <= next_wp_s3;
			wp_q   <= next_wp_q;
		end
	end

	// =====================================================
	// array and write path
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];  // see (RULE_01)
	logic              wq_valid;
	logic              wq_ready;
	snvm_wreq_t        wq_data;
	logic              wb_valid;
	logic              wb_ready;
	snvm_wreq_t        wb_data;

	// array port is busy for reads on the read-load cycle; writes wait then
	logic              rd_load;

	snvm_wbuf #(
		.WIDTH ($bits(snvm_wreq_t))
	) u_wbuf (
		.core_clk_in   (core_clk_in),
		.sys_rst_in    (sys_rst_in),
		.in_valid_in   (wq_valid),
		.in_ready_out  (wq_ready),
		.in_data_in    (wq_data),
		.out_valid_out (wb_valid),
		.out_ready_in  (wb_ready),
		.out_data_out  (wb_data)
	);

	assign wb_ready = ~rd_load;

	always_ff @(posedge core_clk_in) begin
		if (wb_valid && wb_ready) begin
			mem[wb_data.addr] <= wb_data.data;  // see (RULE_07)
		end
	end

	// =====================================================
	// protocol engine
	snvm_state_t        state;
	snvm_state_t        next_state;
	logic [3:0]         bit_cnt;
	logic [3:0]         next_bit_cnt;
	logic [7:0]         shreg;
	logic [7:0]         next_shreg;
	logic [ADDR_W-1:0]  cur_addr;
	logic [ADDR_W-1:0]  next_cur_addr;
	logic [7:0]         addr_hi;
	logic [7:0]         next_addr_hi;
	logic               ack_phase;
	logic               next_ack_phase;
	logic               drive_low;
	logic               next_drive_low;
	logic               tx_mode;
	logic               next_tx_mode;
	logic               stall;
	logic               next_stall;
	logic [7:0]         rd_byte;
	logic [7:0]         rx_byte;
	logic               addr_match;

	assign rx_byte    = {shreg[6:0], line.sda};
	// judged on the fall after the eighth rise, when shreg holds the whole byte
	assign addr_match = (shreg[`SNVM_TYPE_MSB:`SNVM_TYPE_LSB] == `SNVM_TYPE_CODE)
	                  && (shreg[`SNVM_SEL_MSB:`SNVM_SEL_LSB] == sel_q);  // see (RULE_03) see (RULE_11)

	// registered read keeps the array a plain one-port memory
	always_ff @(posedge core_clk_in) begin
		rd_byte <= mem[cur_addr];
	end

	always_comb begin
		next_state     = state;
		next_bit_cnt   = bit_cnt;
		next_shreg     = shreg;
		next_cur_addr  = cur_addr;
		next_addr_hi   = addr_hi;
		next_ack_phase = ack_phase;
		next_drive_low = drive_low;
		next_tx_mode   = tx_mode;
		next_stall     = 1'b0;
		wq_valid       = 1'b0;
		wq_data        = '{addr: cur_addr, data: rx_byte};
		rd_load        = 1'b0;
		if (line.start || line.stop) begin
			// abort; start rearms address reception
			next_state     = line.start ? SNVM_DEVA : SNVM_IDLE;  // see (RULE_14)
			next_bit_cnt   = 4'h0;
			next_ack_phase = 1'b0;
			next_drive_low = 1'b0;
			next_tx_mode   = 1'b0;
		end else if (line.scl_rise) begin
			if (ack_phase) begin
				// master's slot after a sent byte: a released line is no acknowledge
				// and ends the read, so the pin stays free for the stop that follows
				if (state == SNVM_RDAT && !drive_low && line.sda) begin
					next_state = SNVM_IGN;  // see (RULE_13)
				end
			end else if (!tx_mode && state != SNVM_IDLE && state != SNVM_IGN) begin
				next_shreg   = rx_byte;  // see (RULE_05) see (RULE_08)
				next_bit_cnt = bit_cnt + 4'h1;
			end
		end else if (line.scl_fall) begin
			if (ack_phase) begin
				// ack slot ends: release and start next byte
				next_ack_phase = 1'b0;
				next_drive_low = 1'b0;
				next_bit_cnt   = 4'h0;
				if (state == SNVM_RDAT) begin
					next_tx_mode   = 1'b1;
					next_shreg     = rd_byte;
					next_drive_low = ~rd_byte[7];  // see (RULE_10)
					next_cur_addr  = cur_addr + 16'h0001;  // see (RULE_12)
					rd_load        = 1'b1;
				end else begin
					next_tx_mode = 1'b0;
				end
			end else if (tx_mode) begin
				next_bit_cnt = bit_cnt + 4'h1;
				if (bit_cnt == 4'h7) begin
					next_ack_phase = 1'b1;
					next_drive_low = 1'b0;
					next_tx_mode   = 1'b0;
					next_state     = SNVM_RDAT;
				end else begin
					next_shreg     = {shreg[6:0], 1'b1};
					next_drive_low = ~shreg[6];  // see (RULE_05)
				end
			end else if (bit_cnt == 4'h8) begin
				next_ack_phase = 1'b1;
				case (state)
					SNVM_DEVA: begin
						if (addr_match) begin
							next_drive_low = 1'b1;  // see (RULE_13)
							next_state     = shreg[`SNVM_RW_BIT] ? SNVM_RDAT : SNVM_ADRH;
						end else begin
							next_ack_phase = 1'b0;
							next_state     = SNVM_IGN;
						end
					end
					SNVM_ADRH: begin
						next_addr_hi   = shreg;  // see (RULE_02)
						next_drive_low = 1'b1;
						next_state     = SNVM_ADRL;
					end
					SNVM_ADRL: begin
						next_cur_addr  = {addr_hi, shreg};  // see (RULE_02)
						next_drive_low = 1'b1;
						next_state     = SNVM_WDAT;
					end
					SNVM_WDAT: begin
						// buffer full: no ack, master sees failure
						if (wq_ready) begin
							wq_valid       = ~wp_q;  // see (RULE_06)
							wq_data        = '{addr: cur_addr, data: shreg};
							next_cur_addr  = cur_addr + 16'h0001;  // see (RULE_12)
							next_drive_low = 1'b1;
						end else begin
							next_state = SNVM_IGN;
						end
					end
					default: begin
						next_state = SNVM_IGN;
					end
				endcase
			end
		end
		next_stall = stall;
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			state     <= SNVM_IDLE;
			bit_cnt   <= 4'h0;
			shreg     <= 8'h00;
			cur_addr  <= `SNVM_ADDR_ZERO;
			addr_hi   <= 8'h00;
			ack_phase <= 1'b0;
			drive_low <= 1'b0;
			tx_mode   <= 1'b0;
			stall     <= 1'b0;
		end else begin
			state     <= next_state;
			bit_cnt   <= next_bit_cnt;
			shreg     <= next_shreg;
			cur_addr  <= next_cur_addr;
			addr_hi   <= next_addr_hi;
			ack_phase <= next_ack_phase;
			drive_low <= next_drive_low;
			tx_mode   <= next_tx_mode;
			stall     <= next_stall;
		end
	end

	// =====================================================
	// open-drain data pin
	// never driven high, so other agents may pull the line low at any time
	assign sda_out    = 1'b0;       // see (RULE_10)
	assign sda_oe_out = drive_low;  // see (RULE_10)

endmodule : snvm_target
`default_nettype wire

// ==== verilog/snvm_regs.svh ====
// field, geometry and identification constants for the two-wire memory target
// assumes inclusion by bare name from design files
`ifndef SNVM_REGS_SVH
`define SNVM_REGS_SVH

// =====================================================
// target address byte layout
`define SNVM_TYPE_CODE      4'hA
`define SNVM_TYPE_MSB       7
`define SNVM_TYPE_LSB       4
`define SNVM_SEL_MSB        3
`define SNVM_SEL_LSB        1
`define SNVM_RW_BIT         0

// =====================================================
// array geometry
`define SNVM_ADDR_W         16
`define SNVM_DATA_W         8
`define SNVM_ADDR_WRAP      16'hFFFF
`define SNVM_ADDR_ZERO      16'h0000

// =====================================================
// identification (arbitrary neutral values)
`define SNVM_ID_MAKER       12'h123
`define SNVM_ID_DENSITY     4'h5
`define SNVM_ID_REV         8'h01

`endif

// ==== verilog/snvm_pkg.sv ====
// types shared by the two-wire memory target
// assumes nothing beyond a SystemVerilog compiler
package snvm_pkg;

	// receive phase one-hot
	typedef enum logic [6:0] {
		SNVM_IDLE  = 7'b0000001,
		SNVM_DEVA  = 7'b0000010,
		SNVM_ADRH  = 7'b0000100,
		SNVM_ADRL  = 7'b0001000,
		SNVM_WDAT  = 7'b0010000,
		SNVM_RDAT  = 7'b0100000,
		SNVM_IGN   = 7'b1000000
	} snvm_state_t;

	// write request carried to the array
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  data;
	} snvm_wreq_t;

	// synchronised line samples and events
	typedef struct packed {
		logic scl;
		logic sda;
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
	} snvm_line_t;

endpackage : snvm_pkg

// ==== verilog/snvm_line_sync.sv ====
// three-stage synchronisers and bus event detection for clock and data
// assumes both lines idle high through pull-ups
`timescale 1ns/1ps
`default_nettype none
module snvm_line_sync
	import snvm_pkg::*;
(
	input  wire logic       core_clk_in,   // system clock
	input  wire logic       sys_rst_in,    // sync reset
	input  wire logic       scl_in,        // serial clock pin
	input  wire logic       sda_in,        // serial data pin
	output snvm_line_t      line_out       // filtered samples and events
);

	// =====================================================
	// synchronisers
	logic [2:0] scl_sync;
	logic [2:0] sda_sync;
	logic       scl_q;
	logic       sda_q;
	logic [2:0] next_scl_sync;
	logic [2:0] next_sda_sync;
	logic       next_scl_q;
	logic       next_sda_q;

	always_comb begin
		next_scl_sync = {scl_sync[1:0], scl_in};
		next_sda_sync = {sda_sync[1:0], sda_in};
		// a change counts once stages two and three agree
		next_scl_q    = (scl_sync[1] == scl_sync[2]) ? scl_sync[2] : scl_q;  // see (RULE_15)
		next_sda_q    = (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_q;  // see (RULE_15)
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			scl_sync <= 3'h7;
			sda_sync <= 3'h7;
			scl_q    <= 1'b1;
			sda_q    <= 1'b1;
		end else begin
			scl_sync <= next_scl_sync;
			sda_sync <= next_sda_sync;
			scl_q    <= next_scl_q;
			sda_q    <= next_sda_q;
		end
	end

	// =====================================================
	// events
	snvm_line_t next_line;

	always_comb begin
		next_line.scl      = next_scl_q;
		next_line.sda      = next_sda_q;
		next_line.scl_rise = next_scl_q & ~scl_q;
		next_line.scl_fall = ~next_scl_q & scl_q;
		next_line.start    = scl_q & next_scl_q & sda_q & ~next_sda_q;  // see (RULE_15)
		next_line.stop     = scl_q & next_scl_q & ~sda_q & next_sda_q;  // see (RULE_15)
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			line_out <= '{scl: 1'b1, sda: 1'b1, default: 1'b0};
		end else begin
			line_out <= next_line;
		end
	end

endmodule : snvm_line_sync
`default_nettype wire

// ==== verilog/snvm_wbuf.sv ====
// two-entry buffer for write requests between shifter and array
// assumes drain side may stall; source must honour ready
`timescale 1ns/1ps
`default_nettype none
module snvm_wbuf
	import snvm_pkg::*;
#(
	parameter int WIDTH = 24
) (
	input  wire logic             core_clk_in,  // system clock
	input  wire logic             sys_rst_in,   // sync reset
	input  wire logic             in_valid_in,  // source has a word
	output logic                  in_ready_out, // room for a word
	input  wire logic [WIDTH-1:0] in_data_in,   // word in
	output logic                  out_valid_out,// word available
	input  wire logic             out_ready_in, // drain takes it
	output logic [WIDTH-1:0]      out_data_out  // word out
);

	// =====================================================
	// storage
	logic [WIDTH-1:0] mem [0:1];
	logic             wr_ptr;
	logic             rd_ptr;
	logic [1:0]       count;
	logic             next_wr_ptr;
	logic             next_rd_ptr;
	logic [1:0]       next_count;
	logic             push;
	logic             pop;

	assign in_ready_out  = (count != 2'h2);
	assign out_valid_out = (count != 2'h0);
	assign out_data_out  = mem[rd_ptr];

	always_comb begin
		push        = in_valid_in & in_ready_out;
		pop         = out_valid_out & out_ready_in;
		next_wr_ptr = push ? ~wr_ptr : wr_ptr;
		next_rd_ptr = pop ? ~rd_ptr : rd_ptr;
		next_count  = count + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count  <= 2'h0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (push) begin
			mem[wr_ptr] <= in_data_in;
		end
	end

endmodule : snvm_wbuf
`default_nettype wire

// ==== sim/snvm_target_checker.sv ====
// port-level assertions for the two-wire memory target
// assumes the data pin level is the wired level of all pull-downs
`timescale 1ns/1ps
`default_nettype none
module snvm_target_checker (
	input wire logic        core_clk_in,             // system clock
	input wire logic        sys_rst_in,              // sync reset
	input wire logic        scl_in,                  // serial clock pin
	input wire logic        sda_in,                  // wired data level
	input wire logic        sda_out,                 // drive value
	input wire logic        sda_oe_out,              // pull enable
	input wire logic [2:0]  device_select_inputs_in, // strap
	input wire logic        write_protect_in,        // lock
	input wire logic [23:0] ident_out                // identification
);
	// ==========================================================
	// wire rules
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);

	a_sda_low_only: assert property (sda_out == 1'b0)
		else $error("data pin driven high");
	a_ident_fixed: assert property ($stable(ident_out))
		else $error("identification changed");
	// answers follow the clock fall through the synchroniser, never a rise
	a_change_on_fall: assert property ($changed(sda_oe_out) |-> !scl_in && !$past(scl_in, 3))
		else $error("data drive changed outside clock low");
	a_change_not_high: assert property (scl_in [*6] |-> $stable(sda_oe_out))
		else $error("data drive changed while clock high");
	a_ack_holds: assert property ($rose(sda_oe_out) |=> sda_oe_out [*7])
		else $error("pull released too early");
	a_drive_bounded: assert property (sda_oe_out |-> ##[1:400] !sda_oe_out)
		else $error("data line held low too long");
	a_quiet_stop: assert property ($rose(sda_in) && scl_in && $past(scl_in) |-> !sda_oe_out [*6])
		else $error("drive after stop");
	a_quiet_start: assert property ($fell(sda_in) && scl_in && $past(scl_in) |-> !sda_oe_out [*6])
		else $error("drive after start");
	a_quiet_reset: assert property ($fell(sys_rst_in) |-> !sda_oe_out [*8])
		else $error("drive right after reset");

	c_ack: cover property ($rose(sda_oe_out));
	c_stop: cover property ($rose(sda_in) && scl_in && $past(scl_in));
	c_start: cover property ($fell(sda_in) && scl_in && $past(scl_in));
endmodule : snvm_target_checker

bind snvm_target snvm_target_checker i_snvm_target_checker (
	.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .scl_in(scl_in), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe_out(sda_oe_out), .device_select_inputs_in(device_select_inputs_in),
	.write_protect_in(write_protect_in), .ident_out(ident_out));
`default_nettype wire

// ==== sim/snvm_master_model.sv ====
// two-wire bus master model: clock source and data pull-down
// assumes the bench resolves the wired data level with a pull-up
`timescale 1ns/1ps
`default_nettype none
module snvm_master_model (
	input  wire logic clk_in,   // bench clock
	input  wire logic sda_in,   // wired data level
	output logic      scl_out,  // serial clock, high when idle
	output logic      pull_out  // high pulls data low
);
	initial begin
		scl_out = 1'b1;
		pull_out = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge clk_in);
	endtask : wt
	// data moves mid-low so it holds well past the target's sampling delay
	task automatic bit_x(input logic b, output logic s);
		wt(5);
		pull_out = !b;
		wt(5);
		scl_out = 1'b1;
		wt(10);
		s = sda_in;
		scl_out = 1'b0;
	endtask : bit_x
	task automatic start();
		wt(5);
		pull_out = 1'b0;
		wt(5);
		scl_out = 1'b1;
		wt(10);
		pull_out = 1'b1;
		wt(10);
		scl_out = 1'b0;
	endtask : start
	task automatic stop();
		wt(5);
		pull_out = 1'b1;
		wt(5);
		scl_out = 1'b1;
		wt(10);
		pull_out = 1'b0;
		wt(10);
	endtask : stop
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_x(b[i], s);
		bit_x(1'b1, s);
		ack = !s;
	endtask : put_byte
	task automatic get_byte(input logic ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
		bit_x(!ack, s);
	endtask : get_byte
endmodule : snvm_master_model
`default_nettype wire

// ==== sim/snvm_target_bench.sv ====
// self-checking bench for the two-wire memory target
// assumes the master model's tasks are called hierarchically
`timescale 1ns/1ps
`default_nettype none
`include "snvm_regs.svh"
module snvm_target_bench;
	logic        core_clk_in;
	logic        sys_rst_in;
	logic        scl;
	logic        pull;
	logic        sda_oe;
	logic        sda_drv;
	logic        wp;
	logic [2:0]  dsel;
	logic [23:0] ident;
	logic        ack;
	logic [7:0]  d0;
	logic [7:0]  d1;
	wire logic   sda;
	int          n_fail;
	int          total_checks;
	int          cyc;

	// wired-and with pull-up
	assign sda = !pull && !(sda_oe && !sda_drv);

	snvm_target i_snvm_target (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_drv), .sda_oe_out(sda_oe), .device_select_inputs_in(dsel), .write_protect_in(wp),
		.ident_out(ident));
	snvm_master_model i_snvm_master_model (.clk_in(core_clk_in), .sda_in(sda), .scl_out(scl), .pull_out(pull));

	initial begin
		core_clk_in = 1'b0;
		forever #12.5 core_clk_in = ~core_clk_in;
	end
	// ==========================================================
	// helpers
	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic set_addr(input logic [15:0] a);
		i_snvm_master_model.start();
		i_snvm_master_model.put_byte({4'hA, dsel, 1'b0}, ack);
		chk("select ack", 24'h1, {23'h0, ack});
		i_snvm_master_model.put_byte(a[15:8], ack);
		chk("address high ack", 24'h1, {23'h0, ack});
		i_snvm_master_model.put_byte(a[7:0], ack);
		chk("address ack", 24'h1, {23'h0, ack});
	endtask : set_addr
	task automatic wr(input logic [15:0] a, input logic [7:0] x, input logic [7:0] y);
		set_addr(a);
		i_snvm_master_model.put_byte(x, ack);
		chk("data ack", 24'h1, {23'h0, ack});
		i_snvm_master_model.put_byte(y, ack);
		chk("data ack", 24'h1, {23'h0, ack});
		i_snvm_master_model.stop();
	endtask : wr
	// random read: address write, then repeated start, ack one byte and refuse the next
	task automatic rd2(input logic [15:0] a);
		set_addr(a);
		i_snvm_master_model.start();
		i_snvm_master_model.put_byte({4'hA, dsel, 1'b1}, ack);
		i_snvm_master_model.get_byte(1'b1, d0);
		i_snvm_master_model.get_byte(1'b0, d1);
		i_snvm_master_model.stop();
	endtask : rd2
	// ==========================================================
	// scenarios
	task automatic t_ident();
		chk("ident", {`SNVM_ID_MAKER, `SNVM_ID_DENSITY, `SNVM_ID_REV}, ident);
	endtask : t_ident
	task automatic t_seq();
		wr(16'h1234, 8'h3C, 8'hC3);
		rd2(16'h1234);
		chk("read first", 24'h3C, {16'h0, d0});
		chk("read next", 24'hC3, {16'h0, d1});
	endtask : t_seq
	task automatic t_wrap();
		// the byte past the wrap is written first so no read shifts out an unknown
		wr(16'h0001, 8'h96, 8'h69);
		wr(16'hFFFF, 8'h5A, 8'hA5);
		rd2(16'h0000);
		chk("wrapped byte", 24'hA5, {16'h0, d0});
		chk("past wrap", 24'h96, {16'h0, d1});
		rd2(16'hFFFF);
		chk("top byte", 24'h5A, {16'h0, d0});
		chk("after wrap", 24'hA5, {16'h0, d1});
	endtask : t_wrap
	task automatic t_select();
		for (int s = 0; s < 9; s++) begin
			i_snvm_master_model.start();
			i_snvm_master_model.put_byte(s < 8 ? {4'hA, 3'(s), 1'b0} : {4'hB, dsel, 1'b0}, ack);
			chk("select match", {23'h0, s == int'(dsel)}, {23'h0, ack});
			i_snvm_master_model.stop();
		end
	endtask : t_select
	task automatic t_wp();
		wp = 1'b1;
		wr(16'h1234, 8'h11, 8'h22);
		wp = 1'b0;
		rd2(16'h1234);
		chk("protected", 24'h3CC3, {8'h0, d0, d1});
	endtask : t_wp
	// a repeated start halfway through a data byte must drop that byte
	task automatic t_abort();
		logic s;
		wr(16'h2000, 8'h66, 8'h77);
		set_addr(16'h2000);
		for (int i = 0; i < 4; i++) i_snvm_master_model.bit_x(1'b0, s);
		i_snvm_master_model.start();
		i_snvm_master_model.put_byte({4'hA, dsel, 1'b1}, ack);
		i_snvm_master_model.get_byte(1'b0, d0);
		i_snvm_master_model.stop();
		chk("after abort", 24'h66, {16'h0, d0});
	endtask : t_abort
	// ==========================================================
	// run control
	task automatic stop_test();
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test
	// run needs about 13000 cycles
	always @(posedge core_clk_in) begin
		cyc++;
		if (cyc == 60000) begin
			n_fail++;
			stop_test();
		end
	end
	initial begin
		sys_rst_in = 1'b1;
		wp = 1'b0;
		dsel = 3'h5;
		n_fail = 0;
		total_checks = 0;
		cyc = 0;
		repeat (16) @(negedge core_clk_in);
		sys_rst_in = 1'b0;
		repeat (8) @(negedge core_clk_in);
		t_ident();
		t_seq();
		t_wrap();
		t_select();
		t_wp();
		t_abort();
		stop_test();
	end
endmodule : snvm_target_bench
`default_nettype wire
